// >>> rtl/fu_pkg.sv
// shared constants and types of the fast serial channel
package fu_pkg;

  // ----------------------------------------------------------------
  // character and oversampling
  // ----------------------------------------------------------------
  localparam int FU_DATA_W = 8;
  localparam int FU_SUB_W = 4;
  localparam logic [3:0] FU_SUB_LAST = 4'hf;
  localparam logic [3:0] FU_SUB_MID = 4'h7;
  localparam logic [2:0] FU_BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // fifo sizes and transmit thresholds (empty entries)
  // ----------------------------------------------------------------
  localparam int FU_TX_DEPTH = 32;
  localparam int FU_RX_DEPTH = 32;
  localparam int FU_LVL_W = 6;
  localparam logic [5:0] FU_TX_THR_30 = 6'h1e;
  localparam logic [5:0] FU_TX_THR_24 = 6'h18;
  localparam logic [5:0] FU_TX_THR_16 = 6'h10;
  localparam logic [5:0] FU_TX_THR_8 = 6'h08;
  localparam logic [1:0] FU_TRIG_30 = 2'h0;
  localparam logic [1:0] FU_TRIG_24 = 2'h1;
  localparam logic [1:0] FU_TRIG_16 = 2'h2;

  // ----------------------------------------------------------------
  // divisor layout: [15:4] mantissa, [0] prescale select
  // ----------------------------------------------------------------
  localparam int FU_DIV_W = 16;
  localparam int FU_MANT_W = 12;
  localparam int FU_MANT_LSB = 4;
  localparam int FU_PS_BIT = 0;
  localparam int FU_PS_SHIFT = 4;
  localparam logic [15:0] FU_DIV_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // autobaud
  // ----------------------------------------------------------------
  localparam int FU_AB_CNT_W = 20;
  localparam int FU_OVS_SHIFT = 4;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} fu_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fu_rx_t;

endpackage

// >>> rtl/fu_fifo.sv
// synchronous fifo with level count and registered storage
`timescale 1ns/1ps
`default_nettype none
module fu_fifo
  import fu_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH) + 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  assign full = (cnt_reg == CW'(DEPTH));
  assign empty = (cnt_reg == '0);
  assign count = cnt_reg;
  assign rd_data = mem[rp_reg];

  always_comb
  begin
    do_wr = wr_en && !full;
    do_rd = rd_en && !empty;
    wp_next = do_wr ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next = do_rd ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = CW'(cnt_reg + CW'(do_wr) - CW'(do_rd));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wp_reg] <= wr_data;
  end

  fifo_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !full && !rd_en |=> count == $past(count) + 1'b1)
    else $error("fifo count did not follow a write");
endmodule
`default_nettype wire

// >>> rtl/fu_baud.sv
// baud generator: oversample enable and baud clock pulse
`timescale 1ns/1ps
`default_nettype none
module fu_baud
  import fu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [FU_DIV_W-1:0] divisor,
  output logic tick16,
  output logic baud_pulse
);
  logic [FU_DIV_W-1:0] cnt_reg, cnt_next, limit;
  logic [FU_SUB_W-1:0] ph_reg, ph_next;
  logic [FU_MANT_W-1:0] mant;

  // period = (mantissa + 1) * 16^prescale, then /16 for the baud clock
  always_comb
  begin
    mant = divisor[FU_MANT_LSB +: FU_MANT_W];
    if (divisor[FU_PS_BIT])
      limit = FU_DIV_W'({mant, {FU_PS_SHIFT{1'b1}}});
    else
      limit = FU_DIV_W'(mant);
    tick16 = (cnt_reg >= limit);
    cnt_next = tick16 ? '0 : FU_DIV_W'(cnt_reg + 1'b1);
    ph_next = tick16 ? FU_SUB_W'(ph_reg + 1'b1) : ph_reg;
    baud_pulse = tick16 && (ph_reg == FU_SUB_LAST);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      ph_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      ph_reg <= ph_next;
    end
  end

  baud_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick16 && limit != '0 && $stable(divisor) |=> !tick16)
    else $error("oversample enable came too soon");
endmodule
`default_nettype wire

// >>> rtl/fu_uart.sv
// fast serial channel: fifos, service requests, flow control, autobaud
//
// Functional notes
// - empty transmit side raises interrupt or DMA
// - receive shifter stores bytes, raises request
// - errored byte: no DMA request, interrupt instead
// - error interrupt when errored byte reaches head
// - transmit threshold 30, 24, 16 or 8 empty
// - receive fifo at trigger raises request
// - DMA takes only clean bytes, CPU removes errored
// - transmit normally while CTS asserted
// - CTS drop aborts character, not resent
// - DCD high forces receive line high
// - control character match sets flag, interrupt
// - autobaud measures start bit, writes divisor
// - baud = clock / ((mant+1) * 16^ps * 16)
// - reading receive buffer clears valid status
// - in-range divisor replaced by table value
`timescale 1ns/1ps
`default_nettype none
module fu_uart
  import fu_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic DMA_MODE,
  input wire logic FIFO_EN,
  input wire logic [1:0] TX_TRIG_SEL,
  input wire logic [FU_LVL_W-1:0] RX_TRIG_LEVEL,
  input wire logic HW_FLOW_EN,
  input wire logic SW_FLOW_EN,
  input wire logic [7:0] CTRL_CHAR1,
  input wire logic [7:0] CTRL_CHAR2,
  input wire logic CCD_INT_EN,
  input wire logic CCD_CLR,
  input wire logic AUTOBAUD_ENABLE,
  input wire logic [31:0] AUTOBAUD_BOUNDARIES,
  input wire logic [31:0] AUTOBAUD_TABLE,
  input wire logic DIV_WR,
  input wire logic [FU_DIV_W-1:0] DIV_WDATA,
  output logic [FU_DIV_W-1:0] DIVISOR,
  input wire logic TX_WR,
  input wire logic [7:0] TX_WDATA,
  output logic TX_FULL,
  input wire logic RX_RD,
  output logic [7:0] RX_RDATA,
  output logic RX_DATA_ERR,
  output logic RX_VALID,
  output logic TX_INT,
  output logic TX_DMA_REQ,
  output logic RX_INT,
  output logic RX_DMA_REQ,
  output logic ERR_INT,
  output logic CCD_FLAG,
  output logic CCD_INT,
  output logic AUTOBAUD_DONE,
  output logic BAUD_CLOCK_OUT,
  output logic TXD,
  input wire logic RXD,
  input wire logic CTS,
  input wire logic DCD
);
  localparam int CW = $clog2(FU_TX_DEPTH) + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] tx_thr(input logic [1:0] sel);
    unique case (sel)
      FU_TRIG_30: tx_thr = FU_TX_THR_30;
      FU_TRIG_24: tx_thr = FU_TX_THR_24;
      FU_TRIG_16: tx_thr = FU_TX_THR_16;
      default: tx_thr = FU_TX_THR_8;
    endcase
  endfunction

  function automatic logic [11:0] ab_fix(input logic [11:0] d,
    input logic [31:0] bnd, input logic [31:0] tab);
    logic [11:0] b [5];
    ab_fix = d;
    for (int i = 0; i < 4; i++)
      b[i] = {4'h0, bnd[8*i +: 8]};
    b[4] = {4'h0, tab[31:24]};
    for (int i = 0; i < 4; i++)
      if (d > b[i] && d <= b[i+1])
        ab_fix = {4'h0, tab[8*i +: 8]};
  endfunction

  // ----------------------------------------------------------------
  // baud generation and fifos
  // ----------------------------------------------------------------
  logic tick16;
  logic [FU_DIV_W-1:0] div_reg, div_next;

  fu_baud u_baud (
    .clk(MCLK),
    .rst_n(RESETN),
    .divisor(div_reg),
    .tick16(tick16),
    .baud_pulse(BAUD_CLOCK_OUT)
  );

  logic tx_pop, tx_full_f, tx_empty, tx_push;
  logic [7:0] tx_head;
  logic [CW-1:0] tx_cnt;
  logic rx_push, rx_full_f, rx_empty, rx_acc;
  logic [8:0] rx_head, rx_wdata;
  logic [CW-1:0] rx_cnt;

  assign TX_FULL = FIFO_EN ? tx_full_f : !tx_empty;
  assign tx_push = TX_WR && !TX_FULL;

  fu_fifo #(.W(FU_DATA_W), .DEPTH(FU_TX_DEPTH)) u_txf (
    .clk(MCLK),
    .rst_n(RESETN),
    .wr_en(tx_push),
    .wr_data(TX_WDATA),
    .rd_en(tx_pop),
    .rd_data(tx_head),
    .count(tx_cnt),
    .full(tx_full_f),
    .empty(tx_empty)
  );

  assign rx_acc = rx_push && (FIFO_EN ? !rx_full_f : rx_empty);

  fu_fifo #(.W(FU_DATA_W + 1), .DEPTH(FU_RX_DEPTH)) u_rxf (
    .clk(MCLK),
    .rst_n(RESETN),
    .wr_en(rx_acc),
    .wr_data(rx_wdata),
    .rd_en(RX_RD),
    .rd_data(rx_head),
    .count(rx_cnt),
    .full(rx_full_f),
    .empty(rx_empty)
  );

  // ----------------------------------------------------------------
  // service requests
  // ----------------------------------------------------------------
  logic tx_need, rx_need, head_err;
  logic [CW-1:0] tx_free;

  assign tx_free = CW'(FU_TX_DEPTH) - tx_cnt;
  assign tx_need = FIFO_EN ? (tx_free >= CW'(tx_thr(TX_TRIG_SEL)))
                           : tx_empty;
  assign TX_INT = tx_need && !DMA_MODE;
  assign TX_DMA_REQ = tx_need && DMA_MODE;
  assign head_err = !rx_empty && rx_head[FU_DATA_W];
  assign rx_need = FIFO_EN ? (rx_cnt >= CW'(RX_TRIG_LEVEL)) && !rx_empty
                           : !rx_empty;
  assign RX_DMA_REQ = rx_need && DMA_MODE && !head_err;
  assign RX_INT = rx_need && !DMA_MODE && !head_err;
  assign ERR_INT = head_err;
  assign RX_VALID = !rx_empty;
  assign RX_RDATA = rx_head[FU_DATA_W-1:0];
  assign RX_DATA_ERR = head_err;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  fu_tx_t tx_st_reg, tx_st_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_sub_reg, tx_sub_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic txd_reg, txd_next, cts_ok;

  assign cts_ok = !HW_FLOW_EN || CTS;

  always_comb
  begin
    tx_st_next = tx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_sub_next = tx_sub_reg;
    tx_bit_next = tx_bit_reg;
    tx_pop = 1'b0;
    unique case (tx_st_reg)
      TX_IDLE:
        if (tick16 && !tx_empty && cts_ok)
        begin
          tx_st_next = TX_START;
          tx_sh_next = tx_head;
          tx_sub_next = '0;
          tx_pop = 1'b1;
        end
      default:
        if (!cts_ok)
          tx_st_next = TX_IDLE;
        else if (tick16)
        begin
          tx_sub_next = tx_sub_reg + 1'b1;
          if (tx_sub_reg == FU_SUB_LAST)
          begin
            unique case (tx_st_reg)
              TX_START:
              begin
                tx_st_next = TX_DATA;
                tx_bit_next = '0;
              end
              TX_DATA:
              begin
                tx_sh_next = {1'b1, tx_sh_reg[7:1]};
                tx_bit_next = tx_bit_reg + 1'b1;
                if (tx_bit_reg == FU_BIT_LAST)
                  tx_st_next = TX_STOP;
              end
              default: tx_st_next = TX_IDLE;
            endcase
          end
        end
    endcase
    unique case (tx_st_next)
      TX_START: txd_next = 1'b0;
      TX_DATA: txd_next = tx_sh_next[0];
      default: txd_next = 1'b1;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_st_reg <= TX_IDLE;
      tx_sh_reg <= '0;
      tx_sub_reg <= '0;
      tx_bit_reg <= '0;
      txd_reg <= 1'b1;
    end
    else
    begin
      tx_st_reg <= tx_st_next;
      tx_sh_reg <= tx_sh_next;
      tx_sub_reg <= tx_sub_next;
      tx_bit_reg <= tx_bit_next;
      txd_reg <= txd_next;
    end
  end
  assign TXD = txd_reg;

  // ----------------------------------------------------------------
  // receiver and control character detect
  // ----------------------------------------------------------------
  fu_rx_t rx_st_reg, rx_st_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_sub_reg, rx_sub_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic rx_line, ccd_reg, ccd_next, ccd_hit, ab_pend;

  assign rx_line = (HW_FLOW_EN && DCD) ? 1'b1 : RXD;
  assign rx_wdata = {!rx_line, rx_sh_reg};
  assign ccd_hit = SW_FLOW_EN && rx_push && rx_line &&
                   (rx_sh_reg == CTRL_CHAR1 || rx_sh_reg == CTRL_CHAR2);

  always_comb
  begin
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_sub_next = rx_sub_reg;
    rx_bit_next = rx_bit_reg;
    rx_push = 1'b0;
    if (tick16)
    begin
      rx_sub_next = rx_sub_reg + 1'b1;
      unique case (rx_st_reg)
        RX_IDLE:
          if (!rx_line && !ab_pend)
          begin
            rx_st_next = RX_START;
            rx_sub_next = '0;
          end
        RX_START:
          if (rx_sub_reg == FU_SUB_MID)
          begin
            rx_st_next = rx_line ? RX_IDLE : RX_DATA;
            rx_sub_next = '0;
            rx_bit_next = '0;
          end
        RX_DATA:
          if (rx_sub_reg == FU_SUB_LAST)
          begin
            rx_sh_next = {rx_line, rx_sh_reg[7:1]};
            rx_bit_next = rx_bit_reg + 1'b1;
            if (rx_bit_reg == FU_BIT_LAST)
              rx_st_next = RX_STOP;
          end
        RX_STOP:
          if (rx_sub_reg == FU_SUB_LAST)
          begin
            rx_push = 1'b1;
            rx_st_next = RX_IDLE;
          end
      endcase
    end
    ccd_next = ccd_hit || (ccd_reg && !CCD_CLR);
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_st_reg <= RX_IDLE;
      rx_sh_reg <= '0;
      rx_sub_reg <= '0;
      rx_bit_reg <= '0;
      ccd_reg <= 1'b0;
    end
    else
    begin
      rx_st_reg <= rx_st_next;
      rx_sh_reg <= rx_sh_next;
      rx_sub_reg <= rx_sub_next;
      rx_bit_reg <= rx_bit_next;
      ccd_reg <= ccd_next;
    end
  end
  assign CCD_FLAG = ccd_reg;
  assign CCD_INT = ccd_reg && CCD_INT_EN;

  // ----------------------------------------------------------------
  // autobaud and divisor
  // ----------------------------------------------------------------
  logic [FU_AB_CNT_W-1:0] ab_cnt_reg, ab_cnt_next;
  logic ab_run_reg, ab_run_next, ab_done_reg, ab_done_next, ab_fire;
  logic [15:0] ab_q;
  logic [11:0] ab_det, ab_val;

  assign ab_pend = AUTOBAUD_ENABLE && !ab_done_reg;

  always_comb
  begin
    ab_cnt_next = ab_cnt_reg;
    ab_run_next = ab_run_reg;
    ab_done_next = ab_done_reg && AUTOBAUD_ENABLE;
    ab_fire = 1'b0;
    ab_q = 16'(ab_cnt_reg >> FU_OVS_SHIFT);
    ab_det = (ab_q == '0) ? '0 : (|ab_q[15:12]) ? '1
                          : 12'(ab_q - 1'b1);
    ab_val = ab_fix(ab_det, AUTOBAUD_BOUNDARIES, AUTOBAUD_TABLE);
    if (ab_pend && !ab_run_reg && !rx_line)
    begin
      ab_run_next = 1'b1;
      ab_cnt_next = FU_AB_CNT_W'(1);
    end
    else if (ab_run_reg && !rx_line)
      ab_cnt_next = (&ab_cnt_reg) ? ab_cnt_reg
                                  : FU_AB_CNT_W'(ab_cnt_reg + 1'b1);
    else if (ab_run_reg)
    begin
      ab_run_next = 1'b0;
      ab_done_next = 1'b1;
      ab_fire = 1'b1;
    end
    if (ab_fire)
      div_next = {ab_val, 4'h0};
    else if (DIV_WR)
      div_next = DIV_WDATA;
    else
      div_next = div_reg;
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ab_cnt_reg <= '0;
      ab_run_reg <= 1'b0;
      ab_done_reg <= 1'b0;
      div_reg <= FU_DIV_RESET;
    end
    else
    begin
      ab_cnt_reg <= ab_cnt_next;
      ab_run_reg <= ab_run_next;
      ab_done_reg <= ab_done_next;
      div_reg <= div_next;
    end
  end
  assign DIVISOR = div_reg;
  assign AUTOBAUD_DONE = ab_fire;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence tx_hold_s;
    tx_need && !TX_WR ##1 $stable(FIFO_EN) && $stable(TX_TRIG_SEL);
  endsequence

  tx_req_route_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tx_need |-> (DMA_MODE ? TX_DMA_REQ && !TX_INT : TX_INT))
    else $error("transmit service request not raised");
  tx_thresh_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    FIFO_EN && int'(tx_cnt) + int'(tx_thr(TX_TRIG_SEL)) <= FU_TX_DEPTH
      |-> TX_INT || TX_DMA_REQ)
    else $error("transmit threshold missed");
  req_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tx_hold_s |-> tx_need)
    else $error("transmit request dropped without a write");
  rx_err_dma_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    head_err |-> !RX_DMA_REQ && ERR_INT)
    else $error("errored byte offered to DMA");
  cts_abort_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    HW_FLOW_EN && !CTS && tx_st_reg != TX_IDLE
      |=> tx_st_reg == TX_IDLE && TXD)
    else $error("transmit not stopped by CTS");
  dcd_force_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    HW_FLOW_EN && DCD |-> rx_line)
    else $error("receive line not forced high");
  ccd_set_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    ccd_hit |=> CCD_FLAG)
    else $error("control character flag not set");
  rx_valid_clr_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    RX_RD && rx_cnt == CW'(1) && !rx_acc |=> !RX_VALID)
    else $error("receive valid not cleared by read");
  ab_write_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    ab_fire |=> DIVISOR == {$past(ab_val), 4'h0})
    else $error("autobaud result not written");
endmodule
`default_nettype wire

// >>> verification/fu_remote.sv
// remote serial device model: frames, CTS and DCD
`timescale 1ns/1ps
`default_nettype none
module fu_remote
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic cts,
  output logic dcd
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  logic lost;
  initial
  begin
    rxd = 1'b1;
    cts = 1'b1;
    dcd = 1'b0;
  end
  // ----------------------------------------------------------------
  // frames toward the device, 16 cycles a bit, lsb first
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] d, input logic stp,
    input int dcd_at);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      dcd = (i >= dcd_at);
      rxd = (i == 0) ? 1'b0 : (i == 9) ? stp : d[i-1];
      repeat (11) @(negedge clk);
      // short bad stop, so no false start follows it
      if (i == 9)
        rxd = 1'b1;
      repeat (4) @(negedge clk);
    end
    dcd = 1'b0;
  endtask
  task automatic low_pulse(input int k);
    @(negedge clk);
    rxd = 1'b0;
    repeat (k) @(negedge clk);
    rxd = 1'b1;
  endtask
  task automatic set_cts(input logic v);
    cts = v;
  endtask
  // ----------------------------------------------------------------
  // frames from the device; one cut by our CTS drop is dropped
  // ----------------------------------------------------------------
  always
  begin
    @(negedge txd);
    lost = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(negedge clk);
      sh = {txd, sh[7:1]};
      lost = lost | !cts;
    end
    repeat (16) @(negedge clk);
    if (txd && !lost)
      got_q.push_back(sh);
  end
endmodule
`default_nettype wire

// >>> verification/fu_uart_tb.sv
// self-checking bench of the fast serial channel
`timescale 1ns/1ps
`default_nettype none
module fu_uart_tb
  import fu_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic dma_mode = 1'b0;
  logic fifo_en = 1'b1;
  logic [1:0] trig_sel = 2'h0;
  logic [5:0] rx_trig = 6'h02;
  logic hw_flow = 1'b1;
  logic sw_flow = 1'b0;
  logic [7:0] char1 = 8'h13;
  logic [7:0] char2 = 8'h11;
  logic ccd_int_en = 1'b0;
  logic ccd_clr = 1'b0;
  logic ab_en = 1'b0;
  logic [31:0] ab_bnd = 32'h1f0f0703;
  logic [31:0] ab_tab = 32'h170b0502;
  logic div_wr = 1'b0;
  logic [15:0] div_wdata = 16'h0000;
  logic tx_wr = 1'b0;
  logic [7:0] tx_wdata = 8'h00;
  logic rx_rd = 1'b0;
  logic [15:0] divisor;
  logic [7:0] rx_rdata;
  logic tx_full, rx_err, rx_valid, tx_int, tx_dma, rx_int, rx_dma, err_int;
  logic ccd_flag, ccd_int, ab_done, baud_out, txd, rxd, cts, dcd;
  int failures = 0;
  int samples_checked = 0;
  int n;
  int thr[4] = '{30, 24, 16, 8};
  logic [7:0] cc[3] = '{8'h11, 8'h13, 8'h12};
  int lows[2] = '{88, 776};
  logic [15:0] abdiv[2] = '{16'h0020, 16'h02f0};
  logic [15:0] divs[2] = '{16'h0010, 16'h0001};
  logic [15:0] per[2] = '{16'h0020, 16'h0100};
  fu_uart dut (.MCLK(mclk), .RESETN(resetn), .DMA_MODE(dma_mode),
    .FIFO_EN(fifo_en), .TX_TRIG_SEL(trig_sel), .RX_TRIG_LEVEL(rx_trig),
    .HW_FLOW_EN(hw_flow), .SW_FLOW_EN(sw_flow), .CTRL_CHAR1(char1),
    .CTRL_CHAR2(char2), .CCD_INT_EN(ccd_int_en), .CCD_CLR(ccd_clr),
    .AUTOBAUD_ENABLE(ab_en), .AUTOBAUD_BOUNDARIES(ab_bnd),
    .AUTOBAUD_TABLE(ab_tab), .DIV_WR(div_wr), .DIV_WDATA(div_wdata),
    .DIVISOR(divisor), .TX_WR(tx_wr), .TX_WDATA(tx_wdata),
    .TX_FULL(tx_full), .RX_RD(rx_rd), .RX_RDATA(rx_rdata),
    .RX_DATA_ERR(rx_err), .RX_VALID(rx_valid), .TX_INT(tx_int),
    .TX_DMA_REQ(tx_dma), .RX_INT(rx_int), .RX_DMA_REQ(rx_dma),
    .ERR_INT(err_int), .CCD_FLAG(ccd_flag), .CCD_INT(ccd_int),
    .AUTOBAUD_DONE(ab_done), .BAUD_CLOCK_OUT(baud_out), .TXD(txd),
    .RXD(rxd), .CTS(cts), .DCD(dcd));
  fu_remote remote (.clk(mclk), .txd(txd), .rxd(rxd), .cts(cts), .dcd(dcd));
  always #10 mclk = ~mclk;
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic do_reset();
    @(negedge mclk);
    resetn = 1'b0;
    idle(20);
    resetn = 1'b1;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    @(negedge mclk);
    tx_wr = 1'b1;
    tx_wdata = d;
    @(negedge mclk);
    tx_wr = 1'b0;
  endtask
  task automatic rd_byte(input logic [7:0] d, input logic e);
    @(negedge mclk);
    chk("rx data", 16'(rx_rdata), 16'(d));
    chk("rx error", 16'(rx_err), 16'(e));
    rx_rd = 1'b1;
    @(negedge mclk);
    rx_rd = 1'b0;
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic stp, input int at);
    remote.send_byte(d, stp, at);
    idle(4);
  endtask
  task automatic baud_gap();
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (!baud_out && n < 600);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    chk("txd idle", 16'(txd), 16'h0001);
    chk("tx int empty", 16'(tx_int), 16'h0001);
    chk("divisor", divisor, 16'h0000);
    remote.set_cts(1'b0);
    for (int s = 0; s < 4; s++)
    begin
      do_reset();
      trig_sel = 2'(s);
      dma_mode = s[0];
      repeat (32 - thr[s]) wr_byte(8'(s));
      chk("tx int", 16'(tx_int), 16'(!s[0]));
      chk("tx dma", 16'(tx_dma), 16'(s[0]));
      wr_byte(8'h00);
      chk("tx request", 16'(tx_int | tx_dma), 16'h0000);
    end
    repeat (8) wr_byte(8'h5e);
    chk("tx full", 16'(tx_full), 16'h0001);
    remote.set_cts(1'b1);
    idle(6000);
    chk("tx count", 16'(remote.got_q.size()), 16'h0020);
    chk("tx first", 16'(remote.got_q[0]), 16'h0003);
    chk("tx last", 16'(remote.got_q[31]), 16'h005e);
    chk("tx dma empty", 16'(tx_dma), 16'h0001);
    do_reset();
    remote.got_q.delete();
    wr_byte(8'h11);
    wr_byte(8'h22);
    idle(60);
    remote.set_cts(1'b0);
    idle(2);
    chk("txd abort", 16'(txd), 16'h0001);
    idle(200);
    chk("held count", 16'(remote.got_q.size()), 16'h0000);
    remote.set_cts(1'b1);
    idle(200);
    chk("resume count", 16'(remote.got_q.size()), 16'h0001);
    chk("resume byte", 16'(remote.got_q[0]), 16'h0022);
    // single-byte buffer mode on the transmit side
    fifo_en = 1'b0;
    chk("tx buf empty", 16'(tx_dma), 16'h0001);
    wr_byte(8'h66);
    chk("tx buf full", 16'(tx_full), 16'h0001);
    chk("tx buf req", 16'(tx_dma), 16'h0000);
    idle(200);
    chk("tx buf byte", 16'(remote.got_q[1]), 16'h0066);
    chk("tx buf again", 16'(tx_dma), 16'h0001);
    fifo_en = 1'b1;
    dma_mode = 1'b0;
    rx_frame(8'h3c, 1'b1, 10);
    chk("rx valid", 16'(rx_valid), 16'h0001);
    chk("rx int low", 16'(rx_int), 16'h0000);
    rx_frame(8'h5a, 1'b1, 10);
    chk("rx int trig", 16'(rx_int), 16'h0001);
    rd_byte(8'h3c, 1'b0);
    rd_byte(8'h5a, 1'b0);
    chk("rx valid clr", 16'(rx_valid), 16'h0000);
    dma_mode = 1'b1;
    rx_frame(8'h77, 1'b0, 10);
    rx_frame(8'h41, 1'b1, 10);
    chk("err int", 16'(err_int), 16'h0001);
    chk("rx dma err", 16'(rx_dma), 16'h0000);
    rx_trig = 6'h01;
    rd_byte(8'h77, 1'b1);
    chk("err int clr", 16'(err_int), 16'h0000);
    chk("rx dma clean", 16'(rx_dma), 16'h0001);
    rd_byte(8'h41, 1'b0);
    rx_frame(8'h00, 1'b1, 5);
    rd_byte(8'hf0, 1'b0);
    sw_flow = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      ccd_int_en = (k != 1);
      rx_frame(cc[k], 1'b1, 10);
      chk("ccd flag", 16'(ccd_flag), 16'(k != 2));
      chk("ccd int", 16'(ccd_int), 16'(k == 0));
      ccd_clr = 1'b1;
      idle(1);
      ccd_clr = 1'b0;
    end
    do_reset();
    for (int k = 0; k < 2; k++)
    begin
      ab_en = 1'b1;
      remote.low_pulse(lows[k]);
      // done pulse stands only until the next rising edge
      #1;
      chk("ab done", 16'(ab_done), 16'h0001);
      idle(1);
      chk("ab divisor", divisor, abdiv[k]);
      ab_en = 1'b0;
      idle(1);
    end
    for (int k = 0; k < 2; k++)
    begin
      div_wdata = divs[k];
      div_wr = 1'b1;
      idle(1);
      div_wr = 1'b0;
      chk("div load", divisor, divs[k]);
      baud_gap();
      baud_gap();
      baud_gap();
      chk("baud period", 16'(n), per[k]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
